// *** wdgrt_pkg.sv ***
// Shared constants, register layout and timebase tables for the
// windowed watchdog reset timer.
// Assumes a single 10 MHz clock that also serves as the oscillator clock.
package wdgrt_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Control register location and layout
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
   localparam int CTRL_ACT_BIT = 7;
   localparam int CTRL_TOP_BIT = 6;
   localparam int CNT_W = 7;
   localparam int DELAY_W = 6;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h7F;
   localparam logic [CNT_W-1:0] ROLL_FROM = 7'h40;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   // Prescaler figures; PRESCALE_CYCLES and STEP_UNIT in oscillator periods, SHORT_BASE in units of STEP_UNIT
   localparam int PRESCALE_CYCLES = 16384;
   localparam int STEP_UNIT = 64;
   localparam int SHORT_BASE = 192;
   localparam int ACC_STEP = 4;
   localparam int ACC_W = 6;

   // Reset pulse timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_PULSE_CYCLES =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_W = 4;

   // Timebase selection shared with the clock controller
   localparam logic [1:0] TB_2MS = 2'h0;
   localparam logic [1:0] TB_4MS = 2'h1;
   localparam logic [1:0] TB_10MS = 2'h2;
   localparam logic [1:0] TB_25MS = 2'h3;

   // Timing constant MSB for a timebase
   function automatic logic [ACC_W-1:0] wdgrt_tb_msb(input logic [1:0] sel);
      logic [ACC_W-1:0] v;
      v = 6'h04;
      unique case (sel)
         TB_2MS: v = 6'h04;
         TB_4MS: v = 6'h08;
         TB_10MS: v = 6'h14;
         TB_25MS: v = 6'h31;
      endcase
      return v;
   endfunction : wdgrt_tb_msb

   // Timing constant LSB for a timebase
   function automatic logic [ACC_W-1:0] wdgrt_tb_lsb(input logic [1:0] sel);
      logic [ACC_W-1:0] v;
      v = 6'h3B;
      unique case (sel)
         TB_2MS: v = 6'h3B;
         TB_4MS: v = 6'h35;
         TB_10MS: v = 6'h23;
         TB_25MS: v = 6'h36;
      endcase
      return v;
   endfunction : wdgrt_tb_lsb

endpackage : wdgrt_pkg

// *** wdgrt_prescaler.sv ***
// Free-running prescaler that paces the watchdog counter.
// Assumes the timebase select is synchronous to clk.
`timescale 1ns/1ps
module wdgrt_prescaler #(
   parameter int PERIOD = wdgrt_pkg::PRESCALE_CYCLES,
   parameter int UNIT = wdgrt_pkg::STEP_UNIT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] timebaseSelect,
   output logic tick
);
   import wdgrt_pkg::*;

   localparam int W = $clog2(PERIOD + 1);

   logic [W-1:0] cnt_q, cnt_d;
   logic [ACC_W-1:0] acc_q, acc_d;
   logic shortNext_q, shortNext_d;
   logic tick_q, tick_d;
   logic [W-1:0] limit;
   logic [ACC_W:0] accSum;
   logic [ACC_W:0] msbWide;
   logic [ACC_W-1:0] lsb;

   assign tick = tick_q;

   // Some steps are shortened so the average follows the timebase
   always_comb begin
      lsb = wdgrt_tb_lsb(timebaseSelect);
      msbWide = {1'b0, wdgrt_tb_msb(timebaseSelect)};
      limit = shortNext_q ? W'((SHORT_BASE + int'(lsb)) * UNIT)
                          : W'(PERIOD);
      accSum = {1'b0, acc_q} + (ACC_W+1)'(ACC_STEP);
      cnt_d = cnt_q + 1'b1;
      acc_d = acc_q;
      shortNext_d = shortNext_q;
      tick_d = 1'b0;
      if (cnt_q >= limit - 1'b1) begin
         cnt_d = '0;
         tick_d = 1'b1;
         if (accSum >= msbWide) begin
            acc_d = ACC_W'(accSum - msbWide);
            shortNext_d = 1'b1;
         end else begin
            acc_d = ACC_W'(accSum);
            shortNext_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
         acc_q <= '0;
         shortNext_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         shortNext_q <= shortNext_d;
         tick_q <= tick_d;
      end
   end

endmodule : wdgrt_prescaler

// *** wdgrt_reset_pulse.sv ***
// Stretches a one-cycle reset request into an active-low reset pulse.
// Assumes the request is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module wdgrt_reset_pulse #(
   parameter int CYCLES = wdgrt_pkg::RESET_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic trigger,
   output logic resetPinN
);
   import wdgrt_pkg::*;

   logic [PULSE_W-1:0] cnt_q, cnt_d;
   logic pinN_q, pinN_d;

   assign resetPinN = pinN_q;

   always_comb begin
      cnt_d = cnt_q;
      if (trigger) begin
         cnt_d = PULSE_W'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      pinN_d = (cnt_d == '0);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= '0;
         pinN_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         pinN_q <= pinN_d;
      end
   end

endmodule : wdgrt_reset_pulse

// *** wdgrt_watchdog.sv ***
// Top of the windowed watchdog reset timer: control register, counter,
// activation, halt handling and reset generation.
// Assumes a 10 MHz clock, a synchronous active-high reset and option
// levels that are stable while reset is high.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module wdgrt_watchdog #(
   parameter int PRESCALE = wdgrt_pkg::PRESCALE_CYCLES,
   parameter int UNIT = wdgrt_pkg::STEP_UNIT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [wdgrt_pkg::ADDR_W-1:0] address,
   input wire logic [wdgrt_pkg::DATA_W-1:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [wdgrt_pkg::DATA_W-1:0] readData,
   input wire logic [1:0] timebaseSelect,
   input wire logic hwWatchdogOption,
   input wire logic haltResetOption,
   input wire logic haltRequest,
   output logic haltEnter,
   output logic resetPinN
);
   import wdgrt_pkg::*;

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic active_q, active_d;
   logic hwOpt_q, hwOpt_d;
   logic haltOpt_q, haltOpt_d;
   logic [DATA_W-1:0] readData_q, readData_d;
   logic haltEnter_q, haltEnter_d;
   logic tick;
   logic ctrlWrite;
   logic activeEff;
   logic activeAfter;
   logic rollReset;
   logic swReset;
   logic haltReset;
   logic trigger;

   assign readData = readData_q;
   assign haltEnter = haltEnter_q;

   // Shared prescaler, never cleared by register writes
   wdgrt_prescaler #(
      .PERIOD(PRESCALE),
      .UNIT(UNIT)
   ) u_prescaler (
      .clk(clk),
      .reset(reset),
      .timebaseSelect(timebaseSelect),
      .tick(tick)
   );

   wdgrt_reset_pulse #(
      .CYCLES(RESET_PULSE_CYCLES)
   ) u_pulse (
      .clk(clk),
      .reset(reset),
      .trigger(trigger),
      .resetPinN(resetPinN)
   );

   // Option levels are caught while reset is held
   always_comb begin
      hwOpt_d = reset ? hwWatchdogOption : hwOpt_q;
      haltOpt_d = reset ? haltResetOption : haltOpt_q;
   end

   always_ff @(posedge clk) begin
      hwOpt_q <= hwOpt_d;
      haltOpt_q <= haltOpt_d;
   end

   // Counter, activation and reset sources
   always_comb begin
      ctrlWrite = writeStrobe && (address == CTRL_ADDR);
      activeEff = active_q || hwOpt_q;
      cnt_d = cnt_q;
      if (ctrlWrite) begin
         cnt_d = writeData[CNT_W-1:0];
      end else if (tick) begin
         cnt_d = cnt_q - 1'b1;
      end
      // Activation is sticky; a clear written while active is dropped
      active_d = active_q || (ctrlWrite && writeData[CTRL_ACT_BIT]);
      activeAfter = active_d || hwOpt_q;
      rollReset = tick && !ctrlWrite && (cnt_q == ROLL_FROM)
                  && activeEff;
      swReset = ctrlWrite && activeAfter
                && !writeData[CTRL_TOP_BIT];
      haltReset = haltRequest && activeEff && haltOpt_q;
      trigger = rollReset || swReset || haltReset;
      haltEnter_d = haltRequest && !haltReset;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= CTRL_RESET[CNT_W-1:0];
         active_q <= CTRL_RESET[CTRL_ACT_BIT];
         haltEnter_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         active_q <= active_d;
         haltEnter_q <= haltEnter_d;
      end
   end

   // Register read port, data valid in the cycle after the strobe
   always_comb begin
      readData_d = READ_IDLE;
      if (readStrobe && (address == CTRL_ADDR)) begin
         readData_d = {activeEff, cnt_q};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readData_q <= READ_IDLE;
      end else begin
         readData_q <= readData_d;
      end
   end

endmodule : wdgrt_watchdog

// *** wdgrt_checker.sv ***
// Port-level assertions for the watchdog top module.
// Assumes it is bound to wdgrt_watchdog and sees only its ports.
`timescale 1ns/1ps
module wdgrt_checker #(
   parameter int PRESCALE = 256,
   parameter int UNIT = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [wdgrt_pkg::ADDR_W-1:0] address,
   input wire logic [wdgrt_pkg::DATA_W-1:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [wdgrt_pkg::DATA_W-1:0] readData,
   input wire logic [1:0] timebaseSelect,
   input wire logic hwWatchdogOption,
   input wire logic haltResetOption,
   input wire logic haltRequest,
   input wire logic haltEnter,
   input wire logic resetPinN
);
   import wdgrt_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic ctrlWr = writeStrobe && address == CTRL_ADDR;
   wire logic ctrlRd = readStrobe && address == CTRL_ADDR;
   sequence s_low5;
      !resetPinN [*5];
   endsequence
   sequence s_wrRd;
      ctrlWr && writeData[7:6] == 2'h3 ##1 ctrlRd && !writeStrobe;
   endsequence
   property p_pulse;
      $fell(resetPinN) |-> s_low5;
   endproperty
   property p_swReset;
      ctrlWr && writeData[7:6] == 2'h2 |=> !resetPinN;
   endproperty
   property p_haltReset;
      haltRequest && haltResetOption && hwWatchdogOption
         |=> !resetPinN && !haltEnter;
   endproperty
   property p_haltGo;
      haltRequest && !haltResetOption |=> haltEnter;
   endproperty
   property p_haltSrc;
      haltEnter |-> $past(haltRequest);
   endproperty
   property p_rdIdle;
      !$past(readStrobe) |-> readData == READ_IDLE;
   endproperty
   property p_unmapped;
      readStrobe && address != CTRL_ADDR |=> readData == READ_IDLE;
   endproperty
   property p_hwBit;
      ctrlRd && hwWatchdogOption |=> readData[CTRL_ACT_BIT];
   endproperty
   property p_load;
      s_wrRd |=> readData == $past(writeData, 2);
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("short pulse");
   a_swReset: assert property (p_swReset)
      else $error("no sw reset");
   a_haltReset: assert property (p_haltReset)
      else $error("halt");
   a_haltGo: assert property (p_haltGo)
      else $error("no halt entry");
   a_haltSrc: assert property (p_haltSrc)
      else $error("stray halt");
   a_rdIdle: assert property (p_rdIdle)
      else $error("read not idle");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped");
   a_hwBit: assert property (p_hwBit)
      else $error("hw bit low");
   a_load: assert property (p_load)
      else $error("bad readback");
endmodule : wdgrt_checker

// *** wdgrt_watchdog_bench.sv ***
// Self-checking bench for the watchdog, with shortened prescaler.
// Assumes the design and checker files are compiled before it.
`timescale 1ns/1ps
module wdgrt_watchdog_bench;
   import wdgrt_pkg::*;
   localparam int PS = 256;
   logic clk, reset, writeStrobe, readStrobe, haltRequest, haltEnter;
   logic hwWatchdogOption, haltResetOption, resetPinN;
   logic [1:0] timebaseSelect;
   logic [7:0] address, writeData, readData, got;
   int num_errors = 0;
   int checked = 0;
   int n;
   wdgrt_watchdog #(.PRESCALE(PS), .UNIT(1)) uut (.clk(clk),
      .reset(reset), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .readData(readData), .timebaseSelect(timebaseSelect),
      .hwWatchdogOption(hwWatchdogOption),
      .haltResetOption(haltResetOption), .haltRequest(haltRequest),
      .haltEnter(haltEnter), .resetPinN(resetPinN));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         num_errors++;
      end
   endtask : chk
   task do_reset(input logic hw, input logic ho);
      @(posedge clk) reset <= 1;
      hwWatchdogOption <= hw;
      haltResetOption <= ho;
      timebaseSelect <= 2'h0;
      repeat (3) @(posedge clk);
      reset <= 0;
   endtask : do_reset
   // Bus tasks start and end right after a rising edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      writeStrobe <= 1'b1;
      address <= a;
      writeData <= d;
      @(posedge clk) writeStrobe <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      readStrobe <= 1'b1;
      address <= a;
      @(posedge clk) readStrobe <= 1'b0;
      @(posedge clk) d = readData;
   endtask : rd
   // Write the control register and read it back with no gap
   task wr_rd(input logic [7:0] d, output logic [7:0] q);
      writeStrobe <= 1'b1;
      address <= 8'h00;
      writeData <= d;
      @(posedge clk) writeStrobe <= 1'b0;
      readStrobe <= 1'b1;
      @(posedge clk) readStrobe <= 1'b0;
      @(posedge clk) q = readData;
   endtask : wr_rd
   task wait_low(input int lim);
      n = 0;
      #1;
      while (resetPinN === 1'b1 && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask : wait_low
   task halt(input logic [7:0] exp);
      haltRequest <= 1'b1;
      @(posedge clk) haltRequest <= 1'b0;
      @(posedge clk) chk({6'h00, haltEnter, resetPinN}, exp);
   endtask : halt
   task t_regs;
      do_reset(0, 0);
      rd(8'h00, got); chk(got, 8'h7F);
      rd(8'h05, got); chk(got, 8'h00);
      wr_rd(8'hC5, got); chk(got, 8'hC5);
      wr_rd(8'h45, got); chk(got, 8'hC5);
      wr(8'h00, 8'h80);
      wait_low(3); chk(8'(n), 8'h00);
      n = 0;
      while (resetPinN === 1'b0 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk(8'(n), 8'h05);
   endtask : t_regs
   task t_timing;
      do_reset(0, 0);
      wr(8'h00, 8'hC0);
      wait_low(PS + 3); chk({7'h00, resetPinN}, 8'h00);
      do_reset(0, 0);
      wr(8'h00, 8'hC1);
      wait_low(2 * PS + 5); chk({7'h00, resetPinN}, 8'h00);
      chk(n >= 250, 1);
      // Short step of the 2ms timebase is 192 + 59 units
      chk(n == PS + SHORT_BASE + 59, 8'h01);
      do_reset(0, 0);
      timebaseSelect <= TB_25MS;
      wr(8'h00, 8'hC1);
      wait_low(2 * PS + 5);
      chk({7'h00, resetPinN}, 8'h00);
      chk(n == 2 * PS, 8'h01);
   endtask : t_timing
   // Periodic refresh keeps the counter away from the rollover
   task t_refresh;
      do_reset(0, 0);
      n = 0;
      repeat (6) begin
         wr(8'h00, 8'hC1);
         repeat (PS / 2) begin
            @(posedge clk);
            if (resetPinN !== 1'b1) n++;
         end
      end
      chk(8'(n), 8'h00);
   endtask : t_refresh
   task t_free;
      do_reset(0, 0);
      wr(8'h00, 8'h41);
      repeat (3 * PS) @(posedge clk);
      rd(8'h00, got); chk({7'h00, resetPinN}, 1);
      chk(got >= 8'h3D && got <= 8'h3F, 1);
   endtask : t_free
   task t_halt;
      do_reset(0, 1);
      halt(8'h03);
      wr(8'h00, 8'hC5);
      halt(8'h00);
      do_reset(0, 0);
      wr(8'h00, 8'hC5);
      halt(8'h03);
      do_reset(1, 1);
      rd(8'h00, got); chk(got, 8'hFF);
      halt(8'h00);
   endtask : t_halt
   task wrap_up;
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   initial begin
      {reset, writeStrobe, readStrobe, haltRequest} = 4'h8;
      {hwWatchdogOption, haltResetOption} = 2'h0;
      address = 8'h00;
      writeData = 8'h00;
      timebaseSelect = 2'h0;
      t_regs();
      t_timing();
      t_refresh();
      t_free();
      t_halt();
      wrap_up();
   end
   initial begin
      #(20000 * 100);
      num_errors++;
      wrap_up();
   end
endmodule : wdgrt_watchdog_bench
bind wdgrt_watchdog wdgrt_checker #(.PRESCALE(PRESCALE), .UNIT(UNIT)) chk_i (
   .clk(clk), .reset(reset), .address(address), .writeData(writeData),
   .writeStrobe(writeStrobe), .readStrobe(readStrobe),
   .readData(readData), .timebaseSelect(timebaseSelect),
   .hwWatchdogOption(hwWatchdogOption), .haltResetOption(haltResetOption),
   .haltRequest(haltRequest), .haltEnter(haltEnter), .resetPinN(resetPinN));
